// file: rtl/sdm_cfg_reg.sv
// sdm_cfg_reg: one write-enabled configuration register with reset value.
// assumes CLOCK domain and async active-low reset of the top.
`timescale 1ns/1ps
module sdm_cfg_reg #(
    parameter int          W   = 24,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         we_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    // =====================================================================
    // storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_out <= RST;
        end else if (we_in) begin
            q_out <= d_in;
        end
    end
endmodule

// file: rtl/sdm_mode_ctrl.sv
// sdm_mode_ctrl: configuration registers of a fractional-n synthesizer:
// reference, integer and fractional dividers, modulator mode, charge pump
// offset, and vco output divider / doubler through an indirect write word.
// assumes a plain register port on CLOCK_IN, read data one cycle after strobe.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module sdm_mode_ctrl
    import sdm_pkg::*;
#(
    parameter logic DBL_ON = DBL_ON_LEVEL
) (
    input  wire logic              CLOCK_IN,
    input  wire logic              RESET_N_IN,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [DATA_W-1:0] WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [DATA_W-1:0] RDATA_OUT,
    // synthesizer controls
    output logic      [REG_W-1:0]  REF_DIV_OUT,
    output logic      [INT_DIV_W-1:0] INT_DIV_OUT,
    output logic      [FRAC_W-1:0] FRAC_OUT,
    output logic                   FRAC_MODE_OUT,
    output logic                   MOD_EN_OUT,
    output logic                   MOD_BYPASS_OUT,
    output logic      [CP_GAIN_W-1:0] CP_UP_GAIN_OUT,
    output logic      [CP_GAIN_W-1:0] CP_DN_GAIN_OUT,
    output logic                   CP_UP_OFS_EN_OUT,
    output logic                   CP_DN_OFS_EN_OUT,
    output logic      [CP_OFS_W-1:0] CP_OFS_MAG_OUT,
    output logic      [OUT_DIV_W-1:0] OUT_DIV_OUT,
    output logic                   DOUBLER_EN_OUT,
    output logic                   AUTO_BAND_OUT,
    output logic                   DIV_RANGE_OK_OUT
);
    // =====================================================================
    // address decode
    wire logic hit_ref  = (ADDR_IN == OFS_REF_DIV);
    wire logic hit_int  = (ADDR_IN == OFS_INT_DIV);
    wire logic hit_frac = (ADDR_IN == OFS_FRAC_VAL);
    wire logic hit_ind  = (ADDR_IN == OFS_VCO_IND);
    wire logic hit_mod  = (ADDR_IN == OFS_MOD_CFG);
    wire logic hit_cp   = (ADDR_IN == OFS_CP_CTRL);
    wire logic hit_stat = (ADDR_IN == OFS_STATUS);

    wire logic we_ref  = WR_IN && hit_ref;
    wire logic we_int  = WR_IN && hit_int;
    wire logic we_frac = WR_IN && hit_frac;
    wire logic we_ind  = WR_IN && hit_ind;
    wire logic we_mod  = WR_IN && hit_mod;
    wire logic we_cp   = WR_IN && hit_cp;

    wire logic [REG_W-1:0] wdata24 = WDATA_IN[REG_W-1:0];

    // =====================================================================
    // main registers
    logic [REG_W-1:0]     ref_q;
    logic [INT_DIV_W-1:0] int_q;
    logic [FRAC_W-1:0]    frac_q;
    logic [REG_W-1:0]     ind_q;
    logic [REG_W-1:0]     mod_q;
    logic [REG_W-1:0]     cp_q;

    sdm_cfg_reg #(.W(REG_W), .RST(RST_REF_DIV)) u_ref (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_ref),
        .d_in     (wdata24),
        .q_out    (ref_q)
    );

    sdm_cfg_reg #(.W(INT_DIV_W), .RST(RST_INT_DIV)) u_int (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_int),
        .d_in     (WDATA_IN[INT_DIV_W-1:0]),
        .q_out    (int_q)
    );

    sdm_cfg_reg #(.W(FRAC_W), .RST('0)) u_frac (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_frac),
        .d_in     (WDATA_IN[FRAC_W-1:0]),
        .q_out    (frac_q)
    );

    sdm_cfg_reg #(.W(REG_W), .RST('0)) u_ind (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_ind),
        .d_in     (wdata24),
        .q_out    (ind_q)
    );

    sdm_cfg_reg #(.W(REG_W), .RST(RST_MOD_CFG)) u_mod (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_mod),
        .d_in     (wdata24),
        .q_out    (mod_q)
    );

    sdm_cfg_reg #(.W(REG_W), .RST(RST_CP_CTRL)) u_cp (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .we_in    (we_cp),
        .d_in     (wdata24),
        .q_out    (cp_q)
    );

    // =====================================================================
    // indirect vco writes: the word lands, then one cycle later the named
    // vco register takes its data; vco registers have no direct address
    logic                 ind_go_q;
    logic [OUT_DIV_W-1:0] out_div_q;
    logic                 dbl_q;

    wire logic [IND_ADDR_W-1:0] ind_addr = ind_q[IND_ADDR_LSB +: IND_ADDR_W];
    wire logic [IND_DATA_W-1:0] ind_data = ind_q[IND_DATA_LSB +: IND_DATA_W];

    // odd divide values above 1 are not legal and are refused
    wire logic [OUT_DIV_W-1:0] div_req = ind_data[OUT_DIV_W-1:0];
    wire logic div_legal = (div_req == 6'h01) || ((div_req != 6'h00) && !div_req[0]);

    wire logic we_bias = ind_go_q && (ind_addr == VCO_OFS_BIAS) && div_legal;
    wire logic we_dbl  = ind_go_q && (ind_addr == VCO_OFS_DBL);

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ind_go_q <= 1'b0;
        end else begin
            ind_go_q <= we_ind;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            out_div_q <= RST_OUT_DIV;
        end else if (we_bias) begin
            out_div_q <= div_req;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            dbl_q <= RST_DBL;
        end else if (we_dbl) begin
            dbl_q <= ind_data[0];
        end
    end

    // =====================================================================
    // mode decode
    wire logic mod_en     = mod_q[MOD_FRAC_EN];
    wire logic mod_bypass = mod_q[MOD_BYPASS];
    wire logic frac_mode  = mod_en && !mod_bypass;
    // mixed settings are neither mode; treat as integer, safest for lock
    wire logic int_mode   = !frac_mode;

    // integer operation forces zero fractional contribution
    wire logic [FRAC_W-1:0] frac_eff = frac_mode ? frac_q : '0;

    // =====================================================================
    // divider range check per mode
    localparam logic [INT_DIV_W-1:0] LO_INT  = INT_DIV_W'(INT_MIN_INTEGER);
    localparam logic [INT_DIV_W-1:0] HI_INT  = '1;
    localparam logic [INT_DIV_W-1:0] LO_FRAC = INT_DIV_W'(INT_MIN_FRAC);
    localparam logic [INT_DIV_W-1:0] HI_FRAC = INT_DIV_W'(INT_MAX_FRAC);

    wire logic [INT_DIV_W-1:0] lo_sel = frac_mode ? LO_FRAC : LO_INT;
    wire logic [INT_DIV_W-1:0] hi_sel = frac_mode ? HI_FRAC : HI_INT;
    logic range_ok;

    sdm_range_chk #(.W(INT_DIV_W)) u_chk (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RESET_N_IN),
        .val_in   (int_q),
        .lo_in    (lo_sel),
        .hi_in    (hi_sel),
        .ok_out   (range_ok)
    );

    // =====================================================================
    // outputs, all from flip-flops
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            REF_DIV_OUT      <= RST_REF_DIV;
            INT_DIV_OUT      <= RST_INT_DIV;
            FRAC_OUT         <= '0;
            FRAC_MODE_OUT    <= 1'b0;
            MOD_EN_OUT       <= RST_MOD_CFG[MOD_FRAC_EN];
            MOD_BYPASS_OUT   <= RST_MOD_CFG[MOD_BYPASS];
            CP_UP_GAIN_OUT   <= '0;
            CP_DN_GAIN_OUT   <= '0;
            CP_UP_OFS_EN_OUT <= 1'b0;
            CP_DN_OFS_EN_OUT <= 1'b0;
            CP_OFS_MAG_OUT   <= '0;
            OUT_DIV_OUT      <= RST_OUT_DIV;
            DOUBLER_EN_OUT   <= 1'b0;
            AUTO_BAND_OUT    <= 1'b0;
        end else begin
            REF_DIV_OUT      <= ref_q;
            INT_DIV_OUT      <= int_q;
            FRAC_OUT         <= frac_eff;
            FRAC_MODE_OUT    <= frac_mode;
            MOD_EN_OUT       <= mod_en;
            MOD_BYPASS_OUT   <= mod_bypass;
            CP_UP_GAIN_OUT   <= cp_q[CP_UP_GAIN_LSB +: CP_GAIN_W];
            CP_DN_GAIN_OUT   <= cp_q[CP_DN_GAIN_LSB +: CP_GAIN_W];
            CP_UP_OFS_EN_OUT <= cp_q[CP_UP_OFS_EN];
            CP_DN_OFS_EN_OUT <= cp_q[CP_DN_OFS_EN];
            CP_OFS_MAG_OUT   <= cp_q[CP_OFS_LSB +: CP_OFS_W];
            OUT_DIV_OUT      <= out_div_q;
            DOUBLER_EN_OUT   <= (dbl_q == DBL_ON);
            AUTO_BAND_OUT    <= 1'b1;
        end
    end

    // same cycle as the other outputs: the check itself is registered
    assign DIV_RANGE_OK_OUT = range_ok;

    // =====================================================================
    // read port; unmapped addresses read zero
    logic [DATA_W-1:0] rd_mux;
    // status: mode, range flag, doubler bit, full output divider
    wire logic [DATA_W-1:0] stat_full = {20'h00000, 1'b0, int_mode, range_ok,
                                         dbl_q, 2'h0, out_div_q};

    always_comb begin
        rd_mux = '0;
        if (hit_ref) begin
            rd_mux = {8'h00, ref_q};
        end else if (hit_int) begin
            rd_mux = {13'h0000, int_q};
        end else if (hit_frac) begin
            rd_mux = {8'h00, frac_q};
        end else if (hit_ind) begin
            rd_mux = {8'h00, ind_q};
        end else if (hit_mod) begin
            rd_mux = {8'h00, mod_q};
        end else if (hit_cp) begin
            rd_mux = {8'h00, cp_q};
        end else if (hit_stat) begin
            rd_mux = stat_full;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RDATA_OUT <= '0;
        end else if (RD_IN) begin
            RDATA_OUT <= rd_mux;
        end else begin
            RDATA_OUT <= '0;
        end
    end

endmodule

// file: rtl/sdm_pkg.sv
// sdm_pkg: register map, field positions and reset values of the synthesizer
// mode and divider control block; shared by sdm_mode_ctrl, the checker and the testbench.
package sdm_pkg;
    // =====================================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 24;

    // =====================================================================
    // main register offsets (indices on the plain port)
    localparam logic [7:0] OFS_REF_DIV    = 8'h02;
    localparam logic [7:0] OFS_INT_DIV    = 8'h03;
    localparam logic [7:0] OFS_FRAC_VAL   = 8'h04;
    localparam logic [7:0] OFS_VCO_IND    = 8'h05;
    localparam logic [7:0] OFS_MOD_CFG    = 8'h06;
    localparam logic [7:0] OFS_CP_CTRL    = 8'h09;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // =====================================================================
    // vco subsystem register addresses, carried inside the indirect word
    localparam logic [3:0] VCO_OFS_BIAS   = 4'h2;
    localparam logic [3:0] VCO_OFS_DBL    = 4'h3;
    // indirect word layout: [3:0] vco address, [12:4] vco data
    localparam int IND_ADDR_LSB = 0;
    localparam int IND_ADDR_W   = 4;
    localparam int IND_DATA_LSB = 4;
    localparam int IND_DATA_W   = 9;

    // =====================================================================
    // field positions
    localparam int INT_DIV_W      = 19;
    localparam int FRAC_W         = 24;
    localparam int MOD_FRAC_EN    = 11;
    localparam int MOD_BYPASS     = 7;
    localparam int CP_DN_GAIN_LSB = 0;
    localparam int CP_UP_GAIN_LSB = 7;
    localparam int CP_GAIN_W      = 7;
    localparam int CP_OFS_LSB     = 14;
    localparam int CP_OFS_W       = 7;
    localparam int CP_UP_OFS_EN   = 21;
    localparam int CP_DN_OFS_EN   = 22;
    localparam int OUT_DIV_W      = 6;
    localparam int OFS_STEP_UA    = 5;
    localparam int INT_MIN_INTEGER = 16;
    localparam int INT_MIN_FRAC   = 20;
    localparam int INT_MAX_FRAC   = 524284;

    // =====================================================================
    // reset values
    localparam logic [REG_W-1:0]  RST_REF_DIV  = 24'h000001;
    localparam logic [INT_DIV_W-1:0] RST_INT_DIV = 19'h00014;
    localparam logic [REG_W-1:0]  RST_MOD_CFG  = 24'h000080;
    localparam logic [REG_W-1:0]  RST_CP_CTRL  = 24'h000000;
    localparam logic [OUT_DIV_W-1:0] RST_OUT_DIV = 6'h01;
    localparam logic             RST_DBL       = 1'b1;
    // doubler enable level; polarity is not settled, so it is a parameter default
    localparam logic             DBL_ON_LEVEL  = 1'b0;
endpackage

// file: rtl/sdm_range_chk.sv
// sdm_range_chk: registered check that a divider value lies in [lo, hi].
// assumes same clock and reset as the top.
`timescale 1ns/1ps
module sdm_range_chk #(
    parameter int W = 19
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] val_in,
    input  wire logic [W-1:0] lo_in,
    input  wire logic [W-1:0] hi_in,
    output logic              ok_out
);
    // =====================================================================
    // compare
    wire logic ok_d = (val_in >= lo_in) && (val_in <= hi_in);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ok_out <= 1'b0;
        end else begin
            ok_out <= ok_d;
        end
    end
endmodule

// file: tb/sdm_mode_ctrl_chk.sv
// sdm_chk: port-level checks of sdm_mode_ctrl, bound below.
// assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module sdm_chk
    import sdm_pkg::*;
#(
    parameter logic DBL_ON = DBL_ON_LEVEL
) (
    input wire logic                 CLOCK_IN,
    input wire logic                 RESET_N_IN,
    input wire logic [ADDR_W-1:0]    ADDR_IN,
    input wire logic [DATA_W-1:0]    WDATA_IN,
    input wire logic                 WR_IN,
    input wire logic                 RD_IN,
    input wire logic [DATA_W-1:0]    RDATA_OUT,
    input wire logic [REG_W-1:0]     REF_DIV_OUT,
    input wire logic [INT_DIV_W-1:0] INT_DIV_OUT,
    input wire logic [FRAC_W-1:0]    FRAC_OUT,
    input wire logic                 FRAC_MODE_OUT,
    input wire logic                 MOD_EN_OUT,
    input wire logic                 MOD_BYPASS_OUT,
    input wire logic                 CP_UP_OFS_EN_OUT,
    input wire logic                 CP_DN_OFS_EN_OUT,
    input wire logic [CP_OFS_W-1:0]  CP_OFS_MAG_OUT,
    input wire logic [OUT_DIV_W-1:0] OUT_DIV_OUT,
    input wire logic                 DOUBLER_EN_OUT,
    input wire logic                 AUTO_BAND_OUT
);
    // =====================================================================
    // write sequences
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);
    wire logic [5:0] ind_val = WDATA_IN[9:4];
    // divide value must be 1 or a nonzero even value; data bits above the field are ignored
    wire logic       ind_ok  = (ind_val == 6'h01) || (ind_val != 6'h00 && !ind_val[0]);
    sequence s_wr(logic [7:0] a);
        WR_IN && ADDR_IN == a;
    endsequence
    sequence s_ind(logic [3:0] va);
        s_wr(OFS_VCO_IND) ##0 WDATA_IN[3:0] == va;
    endsequence
    // =====================================================================
    // assertions
    AST_INT_MODE: assert property (s_wr(OFS_MOD_CFG) ##0 (!WDATA_IN[11] && WDATA_IN[7])
        |-> ##2 !FRAC_MODE_OUT && !MOD_EN_OUT && MOD_BYPASS_OUT) else $error("integer mode not entered");
    AST_FRAC_MODE: assert property (s_wr(OFS_MOD_CFG) ##0 (WDATA_IN[11] && !WDATA_IN[7])
        |-> ##2 FRAC_MODE_OUT && MOD_EN_OUT && !MOD_BYPASS_OUT) else $error("fractional mode not entered");
    AST_FRAC_ZERO: assert property (!FRAC_MODE_OUT |-> FRAC_OUT == '0)
        else $error("fraction leaks outside fractional mode");
    AST_INT_DIV: assert property (s_wr(OFS_INT_DIV) |-> ##2 INT_DIV_OUT == $past(WDATA_IN[18:0], 2))
        else $error("integer divider not taken");
    AST_FRAC_VAL: assert property (s_wr(OFS_FRAC_VAL) ##1 FRAC_MODE_OUT[*2]
        |-> FRAC_OUT == $past(WDATA_IN[23:0], 2)) else $error("fraction value not taken");
    AST_REF_DIV: assert property (s_wr(OFS_REF_DIV) |-> ##2 REF_DIV_OUT == $past(WDATA_IN[23:0], 2))
        else $error("reference divider not taken");
    AST_CP_OFS: assert property (s_wr(OFS_CP_CTRL) |-> ##2
        {CP_DN_OFS_EN_OUT, CP_UP_OFS_EN_OUT, CP_OFS_MAG_OUT} == $past(WDATA_IN[22:14], 2))
        else $error("charge pump offset fields wrong");
    AST_OUT_DIV_LEGAL: assert property (OUT_DIV_OUT == 6'h01 || (OUT_DIV_OUT != 6'h00 && !OUT_DIV_OUT[0]))
        else $error("output divider holds an illegal value");
    AST_IND_TAKEN: assert property (s_ind(VCO_OFS_BIAS) ##0 ind_ok |-> ##3 OUT_DIV_OUT == $past(ind_val, 3))
        else $error("indirect divider write lost");
    AST_IND_DROP: assert property (s_ind(VCO_OFS_BIAS) ##0 !ind_ok |-> ##3 $stable(OUT_DIV_OUT))
        else $error("illegal divider value accepted");
    AST_DOUBLER: assert property (s_ind(VCO_OFS_DBL) |-> ##3 DOUBLER_EN_OUT == ($past(WDATA_IN[4], 3) == DBL_ON))
        else $error("doubler enable wrong");
    AST_AUTO_BAND: assert property ($past(RESET_N_IN) |-> AUTO_BAND_OUT)
        else $error("auto band select off");
    AST_RD_IDLE: assert property (!RD_IN |=> RDATA_OUT == '0)
        else $error("read data outside read cycle");
endmodule

bind sdm_mode_ctrl sdm_chk #(.DBL_ON(DBL_ON)) u_sdm_chk (
    .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .REF_DIV_OUT(REF_DIV_OUT), .INT_DIV_OUT(INT_DIV_OUT),
    .FRAC_OUT(FRAC_OUT), .FRAC_MODE_OUT(FRAC_MODE_OUT), .MOD_EN_OUT(MOD_EN_OUT),
    .MOD_BYPASS_OUT(MOD_BYPASS_OUT), .CP_UP_OFS_EN_OUT(CP_UP_OFS_EN_OUT), .CP_DN_OFS_EN_OUT(CP_DN_OFS_EN_OUT),
    .CP_OFS_MAG_OUT(CP_OFS_MAG_OUT), .OUT_DIV_OUT(OUT_DIV_OUT), .DOUBLER_EN_OUT(DOUBLER_EN_OUT),
    .AUTO_BAND_OUT(AUTO_BAND_OUT));

// file: tb/testbench.sv
// testbench: drives the register port and compares reads and controls
// with an integer model; assumes the 3-cycle write-to-output path.
`timescale 1ns/1ps
module testbench
    import sdm_pkg::*;
;
    // =====================================================================
    // stimulus, model and checks
    logic         clk   = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   addr  = 8'h00;
    logic [31:0]  wdata = 32'h00000000;
    logic         wr_s  = 1'b0;
    logic         rd_s  = 1'b0;
    wire  [31:0]  rdata;
    wire  [101:0] ctl;
    int           err_total = 0;
    int           checks = 0;
    int           m_ref, m_int, m_frac, m_ind, m_mod, m_cp, m_od, m_dbl;
    bit           in_rst;
    logic [7:0]   regs [8] = '{OFS_REF_DIV, OFS_INT_DIV, OFS_FRAC_VAL, OFS_VCO_IND,
                               OFS_MOD_CFG, OFS_CP_CTRL, OFS_STATUS, 8'h07};
    int           lim [8] = '{15, 16, 19, 20, 524284, 524285, 524287, -1};

    always #10 clk = ~clk;

    sdm_mode_ctrl DUT (
        .CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
        .RDATA_OUT(rdata), .REF_DIV_OUT(ctl[101:78]), .INT_DIV_OUT(ctl[77:59]), .FRAC_OUT(ctl[58:35]),
        .FRAC_MODE_OUT(ctl[34]), .MOD_EN_OUT(ctl[33]), .MOD_BYPASS_OUT(ctl[32]), .CP_UP_GAIN_OUT(ctl[31:25]),
        .CP_DN_GAIN_OUT(ctl[24:18]), .CP_UP_OFS_EN_OUT(ctl[17]), .CP_DN_OFS_EN_OUT(ctl[16]),
        .CP_OFS_MAG_OUT(ctl[15:9]), .OUT_DIV_OUT(ctl[8:3]), .DOUBLER_EN_OUT(ctl[2]), .AUTO_BAND_OUT(ctl[1]),
        .DIV_RANGE_OK_OUT(ctl[0]));

    function automatic logic [101:0] exp_ctl();
        logic fm;
        logic rok;
        fm  = m_mod[11] && !m_mod[7];
        rok = fm ? (m_int >= INT_MIN_FRAC && m_int <= INT_MAX_FRAC) : (m_int >= INT_MIN_INTEGER);
        return {m_ref[23:0], m_int[18:0], fm ? m_frac[23:0] : 24'h000000, fm, m_mod[11], m_mod[7], m_cp[13:7],
                m_cp[6:0], m_cp[21], m_cp[22], m_cp[20:14], m_od[5:0], m_dbl[0] == DBL_ON_LEVEL, !in_rst,
                rok && !in_rst};
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        logic [101:0] e;
        e = exp_ctl();
        case (a)
            OFS_REF_DIV:  return {8'h00, m_ref[23:0]};
            OFS_INT_DIV:  return {13'h0000, m_int[18:0]};
            OFS_FRAC_VAL: return {8'h00, m_frac[23:0]};
            OFS_VCO_IND:  return {8'h00, m_ind[23:0]};
            OFS_MOD_CFG:  return {8'h00, m_mod[23:0]};
            OFS_CP_CTRL:  return {8'h00, m_cp[23:0]};
            OFS_STATUS:   return {21'h000000, !e[34], e[0], m_dbl[0], 2'h0, m_od[5:0]};
            default:      return 32'h00000000;
        endcase
    endfunction

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED read_data at %h expected %h seen %h", a, e, s);
        end
    endtask

    task automatic chk_ctl(input logic [101:0] e, input logic [101:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED controls expected %h seen %h", e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rd_s  <= 1'b0;
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        case (a)
            OFS_REF_DIV:  m_ref = d[23:0];
            OFS_INT_DIV:  m_int = d[18:0];
            OFS_FRAC_VAL: m_frac = d[23:0];
            OFS_MOD_CFG:  m_mod = d[23:0];
            OFS_CP_CTRL:  m_cp = d[23:0];
            OFS_VCO_IND: begin
                m_ind = d[23:0];
                if (d[3:0] == VCO_OFS_BIAS && (d[9:4] == 6'h01 || (d[9:4] != 6'h00 && !d[4])))
                    m_od = d[9:4];
                if (d[3:0] == VCO_OFS_DBL)
                    m_dbl = d[4];
            end
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] a);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk_rd(a, exp_rd(a), rdata);
        @(posedge clk);
    endtask

    // three edges cover the slowest outputs, the indirect output divider and doubler
    task automatic settle();
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_ctl(exp_ctl(), ctl);
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst_n  <= 1'b0;
        wr_s   <= 1'b0;
        rd_s   <= 1'b0;
        in_rst = 1'b1;
        m_ref  = RST_REF_DIV;
        m_int  = RST_INT_DIV;
        m_frac = 0;
        m_ind  = 0;
        m_mod  = RST_MOD_CFG;
        m_cp   = RST_CP_CTRL;
        m_od   = RST_OUT_DIV;
        m_dbl  = RST_DBL;
        repeat (4) @(posedge clk);
        #1;
        chk_ctl(exp_ctl(), ctl);
        chk_rd(8'h00, 32'h00000000, rdata);
        @(posedge clk);
        rst_n  <= 1'b1;
        in_rst = 1'b0;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial begin
        logic [6:0] g;
        logic       fm;
        void'($urandom(9725));
        do_reset();
        settle();
        foreach (regs[i]) rd(regs[i]);
        // random writes, including the read-only status and a hole
        repeat (30) begin
            g = 7'($urandom_range(0, 7));
            wr(regs[g], $urandom());
            rd(regs[g]);
        end
        settle();
        // every mode bit pair, offset chosen to suit the mode
        for (int i = 0; i < 4; i++) begin
            g  = 7'($urandom());
            fm = i[1] && !i[0];
            wr(OFS_FRAC_VAL, $urandom());
            wr(OFS_MOD_CFG, {20'h00000, i[1], 3'h0, i[0], 7'h00});
            wr(OFS_CP_CTRL, {9'h000, fm, 1'b0, fm ? g >> 1 : 7'h00, g, g});
            settle();
            rd(OFS_STATUS);
        end
        // divider range limits in both modes
        foreach (lim[i]) begin
            for (int f = 0; f < 2; f++) begin
                wr(OFS_MOD_CFG, f ? 32'h00000800 : 32'h00000080);
                wr(OFS_INT_DIV, lim[i]);
                settle();
                rd(OFS_INT_DIV);
            end
        end
        // indirect writes, every divider code and both doubler levels
        for (int v = 0; v < 64; v++) begin
            wr(OFS_VCO_IND, {19'h00000, 3'h0, v[5:0], VCO_OFS_BIAS});
            wr(OFS_VCO_IND, {19'h00000, 8'h00, v[0], VCO_OFS_DBL});
            settle();
        end
        rd(OFS_STATUS);
        do_reset();
        settle();
        foreach (regs[i]) rd(regs[i]);
        give_verdict();
    end
endmodule
